/* File: design/gpio_irq_detect.sv */
// per-pin trigger detection and raw status latch
// assumes pin levels already synchronised to i_clk
`timescale 1ns/100ps
`include "gpio_irq_pad_params.svh"
module gpio_irq_detect
    import gpio_irq_pad_pkg::*;
(
    // clock and reset
    input  wire logic      i_clk,
    input  wire logic      i_nrst,
    // pin level and configuration
    input  wire pin_vec_t  i_level,
    input  wire pin_vec_t  i_sense,
    input  wire pin_vec_t  i_dual,
    input  wire pin_vec_t  i_pol,
    input  wire pin_vec_t  i_clear,
    // raw status
    output pin_vec_t       o_raw
);
    typedef struct packed {
        pin_vec_t last;
        pin_vec_t latch;
    } det_state_t;

    det_state_t st_r;
    det_state_t st_nxt;
    pin_vec_t   edge_hit;
    pin_vec_t   level_hit;

    genvar g;
    generate
        for (g = 0; g < `GP_PINS; g++) begin : g_pin
            logic rise;
            logic fall;
            assign rise = i_level[g] & ~st_r.last[g];
            assign fall = ~i_level[g] & st_r.last[g];
            assign edge_hit[g] = i_dual[g] ? (rise | fall)            // [R19]
                                           : (i_pol[g] ? rise : fall); // [R1]
            assign level_hit[g] = i_pol[g] ? i_level[g] : ~i_level[g]; // [R1]
        end
    endgenerate

    always_comb begin
        st_nxt      = st_r;
        st_nxt.last = i_level;
        // a new edge wins over a clear in the same cycle
        st_nxt.latch = (st_r.latch & ~i_clear) | (edge_hit & ~i_sense); // [R6]
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // level pins bypass the latch, so a clear cannot hold while level stays
    assign o_raw = (i_sense & level_hit) | (~i_sense & st_r.latch); // [R18] [R7] [R3]
endmodule // gpio_irq_detect

/* File: design/gpio_irq_pad.sv */
// interrupt detection and pad control registers for one eight-pin port
// assumes a plain single-cycle register port and asynchronous pin inputs
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`include "gpio_irq_pad_params.svh"
module gpio_irq_pad #(
    parameter gpio_irq_pad_pkg::debug_group_t DEBUG_GROUP = gpio_irq_pad_pkg::DBG_NONE
) (
    // clock and reset
    input  wire logic                        i_clk,
    input  wire logic                        i_nrst,
    // register port
    input  wire gpio_irq_pad_pkg::reg_addr_t i_addr,
    input  wire gpio_irq_pad_pkg::bus_word_t i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output gpio_irq_pad_pkg::bus_word_t      o_rdata,
    // pins
    input  wire gpio_irq_pad_pkg::pin_vec_t  i_pins,
    // pad and mux control
    output gpio_irq_pad_pkg::pin_vec_t       o_direction,
    output gpio_irq_pad_pkg::pin_vec_t       o_function_select,
    output gpio_irq_pad_pkg::pin_vec_t       o_low_drive,
    output gpio_irq_pad_pkg::pin_vec_t       o_mid_drive,
    output gpio_irq_pad_pkg::pin_vec_t       o_high_drive,
    // interrupts
    output gpio_irq_pad_pkg::pin_vec_t       o_pin_irq,
    output logic                             o_combined_port_interrupt
);
    import gpio_irq_pad_pkg::*;

    function automatic logic hit(input reg_addr_t a, input reg_addr_t ofs);
        hit = (a == ofs);
    endfunction

    function automatic pin_vec_t function_select_field_reset(input debug_group_t grp);
        unique case (grp)
            DBG_ONE_LINE:   function_select_field_reset = `GP_RST_FUNCTION_SELECT_FIELD_ONE;
            DBG_FOUR_LINES: function_select_field_reset = `GP_RST_FUNCTION_SELECT_FIELD_FOUR;
            DBG_NONE:       function_select_field_reset = `GP_RST_ZERO;
            default:        function_select_field_reset = `GP_RST_ZERO;
        endcase
    endfunction

    typedef struct packed {
        pin_vec_t  sync1;
        pin_vec_t  sync2;
        pin_vec_t  direction;
        pin_vec_t  sense;
        pin_vec_t  dual;
        pin_vec_t  pol;
        pin_vec_t  enable;
        pin_vec_t  function_select_field;
        pin_vec_t  drv_lo;
        pin_vec_t  drv_mid;
        pin_vec_t  drv_hi;
        pin_vec_t  kill_lo;
        pin_vec_t  kill_mid;
        pin_vec_t  kill_hi;
        bus_word_t rdata;
    } regs_t;

    regs_t    st_r;
    regs_t    st_nxt;
    pin_vec_t raw;
    pin_vec_t masked;
    pin_vec_t clear_req;
    pin_vec_t wbyte;

    assign wbyte = i_wdata[7:0];
    assign clear_req = (i_wr && hit(i_addr, `GP_OFS_CLR)) ? wbyte : '0; // [R6]

    gpio_irq_detect u_detect (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_level (st_r.sync2),
        .i_sense (st_r.sense),
        .i_dual  (st_r.dual),
        .i_pol   (st_r.pol),
        .i_clear (clear_req),
        .o_raw   (raw)
    );

    assign masked = raw & st_r.enable; // [R2] [R4]

    always_comb begin
        st_nxt       = st_r;
        st_nxt.sync1 = i_pins;
        st_nxt.sync2 = st_r.sync1;

        // competing drive bits drop one cycle after the write lands,
        // so the clear shows on the second edge after the write
        st_nxt.drv_lo   = st_r.drv_lo & ~st_r.kill_lo;    // [R15]
        st_nxt.drv_mid  = st_r.drv_mid & ~st_r.kill_mid;  // [R15]
        st_nxt.drv_hi   = st_r.drv_hi & ~st_r.kill_hi;    // [R15]
        st_nxt.kill_lo  = '0;
        st_nxt.kill_mid = '0;
        st_nxt.kill_hi  = '0;

        if (i_wr) begin
            unique case (i_addr)
                `GP_OFS_DIR:   st_nxt.direction = wbyte;
                `GP_OFS_SENSE: st_nxt.sense     = wbyte; // [R18]
                `GP_OFS_DUAL:  st_nxt.dual      = wbyte; // [R19]
                `GP_OFS_POL:   st_nxt.pol       = wbyte; // [R1]
                `GP_OFS_EN:    st_nxt.enable    = wbyte; // [R2]
                `GP_OFS_FUNCTION_SELECT_FIELD: st_nxt.function_select_field     = wbyte; // [R8]
                `GP_OFS_DRV_LO: begin
                    st_nxt.drv_lo   = wbyte;
                    st_nxt.kill_mid = wbyte; // [R12]
                    st_nxt.kill_hi  = wbyte; // [R12]
                end
                `GP_OFS_DRV_MID: begin
                    st_nxt.drv_mid  = wbyte;
                    st_nxt.kill_lo  = wbyte; // [R13]
                    st_nxt.kill_hi  = wbyte; // [R13]
                end
                `GP_OFS_DRV_HI: begin
                    st_nxt.drv_hi   = wbyte;
                    st_nxt.kill_lo  = wbyte; // [R14]
                    st_nxt.kill_mid = wbyte; // [R14]
                end
                default: ;
            endcase
        end

        // upper bits read as zero; unmapped offsets read zero
        st_nxt.rdata = '0;
        if (i_rd) begin
            unique case (i_addr)
                `GP_OFS_DIR:     st_nxt.rdata[7:0] = st_r.direction;
                `GP_OFS_SENSE:   st_nxt.rdata[7:0] = st_r.sense;
                `GP_OFS_DUAL:    st_nxt.rdata[7:0] = st_r.dual;
                `GP_OFS_POL:     st_nxt.rdata[7:0] = st_r.pol;
                `GP_OFS_EN:      st_nxt.rdata[7:0] = st_r.enable;
                `GP_OFS_RAW:     st_nxt.rdata[7:0] = raw;    // [R3]
                `GP_OFS_MSK:     st_nxt.rdata[7:0] = masked; // [R4]
                `GP_OFS_FUNCTION_SELECT_FIELD:   st_nxt.rdata[7:0] = st_r.function_select_field;
                `GP_OFS_DRV_LO:  st_nxt.rdata[7:0] = st_r.drv_lo;
                `GP_OFS_DRV_MID: st_nxt.rdata[7:0] = st_r.drv_mid;
                `GP_OFS_DRV_HI:  st_nxt.rdata[7:0] = st_r.drv_hi;
                default:         st_nxt.rdata      = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r        <= '0;
            st_r.function_select_field  <= function_select_field_reset(DEBUG_GROUP); // [R9] [R10]
            st_r.drv_lo <= `GP_RST_DRV_LO;           // [R16]
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata                   = st_r.rdata;
    assign o_direction               = st_r.direction; // [R10]
    assign o_function_select         = st_r.function_select_field;     // [R8]
    assign o_low_drive               = st_r.drv_lo;
    assign o_mid_drive               = st_r.drv_mid;
    assign o_high_drive              = st_r.drv_hi;
    assign o_pin_irq                 = masked;         // [R2]
    assign o_combined_port_interrupt = |masked;        // [R5]
endmodule // gpio_irq_pad

/* File: design/gpio_irq_pad_params.svh */
// constants for the port interrupt and pad control block
// assumes a 32-bit plain register port with byte offsets and eight pins
//
// Contract
// R1 - polarity bit 1 triggers rising edge or high level, 0 falling or low.
// R2 - enable bit 1 lets a pin's condition reach its interrupt and combined line.
// R3 - raw status reads 1 once the trigger condition is met, regardless of mask.
// R4 - masked status equals raw status ANDed with the pin enable.
// R5 - combined interrupt is high while any masked status bit is set.
// R6 - writing 1 to clear register clears the pin's edge latch; 0 no effect.
// R7 - level-sensitive pins show raw status following the active level directly.
// R8 - function select 1 gives the line to alternate hardware, 0 to software.
// R9 - function select resets to zero except debug lines: 0x80 or 0x0f.
// R10 - any reset returns function select and direction to their defaults.
// R11 - boot software keeps a way to restore debug function on the lines.
// R12 - writing 1 to low-drive bit clears that pin's mid and high bits.
// R13 - writing 1 to mid-drive bit clears that pin's low and high bits.
// R14 - writing 1 to high-drive bit clears that pin's low and mid bits.
// R15 - competing drive bits clear on the second clock after the write.
// R16 - reset selects low drive 0xff, mid and high drive zero.
// R17 - software leaves bits 31:8 alone and ignores their read value.
// R18 - sense bit 1 makes detection level-sensitive, 0 edge-sensitive.
// R19 - edge pins with dual-edge bit set trigger on both edges.
`ifndef GPIO_IRQ_PAD_PARAMS_SVH
`define GPIO_IRQ_PAD_PARAMS_SVH

`define GP_ADDR_W          12
`define GP_PINS            8
`define GP_OFS_DIR         12'h400
`define GP_OFS_SENSE       12'h404
`define GP_OFS_DUAL        12'h408
`define GP_OFS_POL         12'h40c
`define GP_OFS_EN          12'h410
`define GP_OFS_RAW         12'h414
`define GP_OFS_MSK         12'h418
`define GP_OFS_CLR         12'h41c
`define GP_OFS_FUNCTION_SELECT_FIELD       12'h420
`define GP_OFS_DRV_LO      12'h500
`define GP_OFS_DRV_MID     12'h504
`define GP_OFS_DRV_HI      12'h508
`define GP_RST_DRV_LO      8'hff
`define GP_RST_ZERO        8'h00
`define GP_RST_FUNCTION_SELECT_FIELD_ONE   8'h80
`define GP_RST_FUNCTION_SELECT_FIELD_FOUR  8'h0f

`endif

/* File: design/gpio_irq_pad_pkg.sv */
// types for the port interrupt and pad control block
// assumes the constants header sits beside it
package gpio_irq_pad_pkg;
    typedef logic [7:0]  pin_vec_t;
    typedef logic [11:0] reg_addr_t;
    typedef logic [31:0] bus_word_t;

    // which debug lines this port instance holds
    typedef enum logic [1:0] {
        DBG_NONE,
        DBG_ONE_LINE,
        DBG_FOUR_LINES
    } debug_group_t;
endpackage

/* File: dv/gpio_irq_pad_props.sv */
// concurrent checks on the port block outputs
// assumes it is bound into gpio_irq_pad and sees only its ports
`timescale 1ns/100ps
module gpio_irq_pad_props
    import gpio_irq_pad_pkg::*;
#(
    parameter debug_group_t DEBUG_GROUP = DBG_NONE
) (
    input wire logic      i_clk, i_nrst, i_wr, i_rd, o_combined_port_interrupt,
    input wire reg_addr_t i_addr,
    input wire bus_word_t i_wdata, o_rdata,
    input wire pin_vec_t  i_pins, o_direction, o_function_select,
    input wire pin_vec_t  o_low_drive, o_mid_drive, o_high_drive, o_pin_irq
);
    localparam pin_vec_t AFS = (DEBUG_GROUP == DBG_ONE_LINE) ? 8'h80 :
                               (DEBUG_GROUP == DBG_FOUR_LINES) ? 8'h0f : 8'h00;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    property p_comb; o_combined_port_interrupt == |o_pin_irq; endproperty
    a_comb: assert property (p_comb) else $error("combined line wrong");
    property p_lo_wins; i_wr && i_addr == 12'h500 |-> ##2 ((o_mid_drive | o_high_drive) & $past(i_wdata[7:0], 2)) == 8'h00; endproperty
    a_lo_wins: assert property (p_lo_wins) else $error("low drive not exclusive");
    property p_mid_wins; i_wr && i_addr == 12'h504 |-> ##2 ((o_low_drive | o_high_drive) & $past(i_wdata[7:0], 2)) == 8'h00; endproperty
    a_mid_wins: assert property (p_mid_wins) else $error("mid drive not exclusive");
    property p_hi_wins; i_wr && i_addr == 12'h508 |-> ##2 ((o_low_drive | o_mid_drive) & $past(i_wdata[7:0], 2)) == 8'h00; endproperty
    a_hi_wins: assert property (p_hi_wins) else $error("high drive not exclusive");
    property p_mis_rd; i_rd && i_addr == 12'h418 |=> o_rdata == {24'h000000, $past(o_pin_irq)}; endproperty
    a_mis_rd: assert property (p_mis_rd) else $error("masked status read wrong");
    property p_en_blocks; i_wr && i_addr == 12'h410 |=> (o_pin_irq & ~$past(i_wdata[7:0])) == 8'h00; endproperty
    a_en_blocks: assert property (p_en_blocks) else $error("disabled pin interrupts");
    property p_drv_rst; $rose(i_nrst) |-> {o_low_drive, o_mid_drive, o_high_drive, o_direction} == 32'hff000000; endproperty
    a_drv_rst: assert property (p_drv_rst) else $error("drive reset wrong");
    property p_afs_rst; $rose(i_nrst) |-> o_function_select == AFS && o_pin_irq == 8'h00; endproperty
    a_afs_rst: assert property (p_afs_rst) else $error("function select reset wrong");
endmodule // gpio_irq_pad_props
bind gpio_irq_pad gpio_irq_pad_props #(.DEBUG_GROUP(DEBUG_GROUP)) i_gpio_irq_pad_props (.*);

/* File: dv/gpio_irq_pad_tb.sv */
// self-checking bench for the port interrupt and pad control block
// assumes the checker is bound in and the pin model drives the pins
`timescale 1ns/100ps
module gpio_irq_pad_tb;
    import gpio_irq_pad_pkg::*;
    logic      i_clk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, rd_q = 1'b0, o_combined_port_interrupt;
    reg_addr_t i_addr = 12'h000;
    bus_word_t i_wdata = 32'h00000000, o_rdata;
    pin_vec_t  want = 8'h00, i_pins, o_direction, o_function_select, o_low_drive, o_mid_drive, o_high_drive;
    pin_vec_t  o_pin_irq, lo, mi, hi, v;
    int        fail_count = 0, n_checks = 0;
    bus_word_t exp_q[$];
    gpio_irq_pad #(.DEBUG_GROUP(DBG_ONE_LINE)) i_gpio_irq_pad (.*);
    gpio_pin_model i_gpio_pin_model (.i_clk(i_clk), .i_want(want), .o_pins(i_pins));
    initial forever #5 i_clk = ~i_clk;
    task automatic chk(string nm, bus_word_t seen, bus_word_t exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one idle cycle after each access so no strobe is driven twice in one step
    task automatic wr(reg_addr_t a, pin_vec_t d);
        i_addr <= a; i_wdata <= {24'h000000, d}; i_wr <= 1'b1;
        @(posedge i_clk); i_wr <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rd(reg_addr_t a, pin_vec_t e);
        exp_q.push_back({24'h000000, e});
        i_addr <= a; i_rd <= 1'b1;
        @(posedge i_clk); i_rd <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic settle;
        repeat (5) @(posedge i_clk);
    endtask
    // read data stand only in the cycle after the strobe, so look mid-cycle
    always @(posedge i_clk) rd_q <= i_rd;
    always @(negedge i_clk) if (rd_q) chk("rdata", o_rdata, exp_q.pop_front());
    initial begin
        #100000;
        fail_count++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'he3e61357));
        repeat (3) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        {lo, mi, hi} = 24'hff0000;
        rd(12'h420, 8'h80);
        rd(12'h40c, 8'h00);
        rd(12'h600, 8'h00);
        for (int k = 0; k < 6; k++) begin
            v = 8'h01 << $urandom_range(7);
            wr(12'h500 + 12'(4 * (k % 3)), v);
            // a write replaces the whole field, then clears the rivals
            lo = (k % 3 == 0) ? v : lo & ~v;
            mi = (k % 3 == 1) ? v : mi & ~v;
            hi = (k % 3 == 2) ? v : hi & ~v;
            for (int j = 0; j < 3; j++) rd(12'h500 + 12'(4 * j), j == 0 ? lo : j == 1 ? mi : hi);
        end
        wr(12'h410, 8'h0f);
        wr(12'h40c, 8'hff);
        v = 8'($urandom) | 8'h01;
        want <= v;
        settle();
        rd(12'h414, v);
        rd(12'h418, v & 8'h0f);
        chk("irq", o_combined_port_interrupt, 1);
        wr(12'h41c, 8'h00);
        rd(12'h414, v);
        wr(12'h41c, 8'hff);
        rd(12'h414, 8'h00);
        wr(12'h40c, 8'h00);
        wr(12'h41c, 8'hff);
        want <= 8'h00;
        settle();
        rd(12'h414, v);
        wr(12'h410, 8'h00);
        rd(12'h418, 8'h00);
        chk("irq", o_combined_port_interrupt, 0);
        wr(12'h40c, 8'hff);
        wr(12'h404, 8'hff);
        want <= 8'h5a;
        settle();
        wr(12'h41c, 8'hff);
        rd(12'h414, 8'h5a);
        wr(12'h404, 8'h00);
        wr(12'h408, 8'hff);
        wr(12'h41c, 8'hff);
        want <= 8'h0f;
        settle();
        wr(12'h410, 8'hff);
        rd(12'h414, 8'h55);
        chk("irq", o_combined_port_interrupt, 1);
        v = 8'($urandom);
        wr(12'h420, v);
        chk("function_select_field", o_function_select, v);
        // boot code hands the debug line back before anything else
        wr(12'h420, v | 8'h80);
        rd(12'h420, v | 8'h80);
        wr(12'h400, 8'hff);
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk("pads", {o_function_select, o_direction, o_low_drive}, 24'h8000ff);
        i_nrst <= 1'b1;
        settle();
        print_verdict();
    end
endmodule // gpio_irq_pad_tb

/* File: dv/gpio_pin_model.sv */
// far-side pin driver: moves the port pins to the level the bench asks for
// assumes one clock; pins are asynchronous to the block, so they move off the edge
`timescale 1ns/100ps
module gpio_pin_model
    import gpio_irq_pad_pkg::*;
(
    // clock
    input  wire logic     i_clk,
    // requested level and pins
    input  wire pin_vec_t i_want,
    output pin_vec_t      o_pins
);
    initial o_pins = 8'h00;
    // a small skew keeps pin changes clear of the sampling edge
    always @(posedge i_clk) o_pins <= #2 i_want;
endmodule // gpio_pin_model
